// >>> bench/abort_discard_props.sv
// Concurrent checks on the abort discard block ports
`timescale 1ns/10ps
module abort_discard_props
  import abort_discard_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic STORE_ISSUE,
  input wire logic RESP_VALID,
  input wire logic [1:0] RESP_CODE,
  input wire logic RESP_NORMAL_MEM,
  input wire logic ABORT_MASKED,
  input wire logic IN_DEBUG_HALT,
  input wire logic ABORT_DISCARD,
  input wire logic ASYNC_ABORT_STICKY_FLAG,
  input wire logic ABORT_PENDING,
  input wire logic ABORT_EXCEPTION
);
  wire logic ab = RESP_VALID && RESP_NORMAL_MEM && RESP_CODE == BUS_RESP_SLVERR;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_halt_abort_dropped: assert property (ab && ABORT_DISCARD |=> ASYNC_ABORT_STICKY_FLAG && !ABORT_EXCEPTION)
    else $error("abort in halt not dropped");
  a_drain_before_halt: assert property (!IN_DEBUG_HALT && (STORE_ISSUE || ab) |=> !IN_DEBUG_HALT [*4])
    else $error("halt entered before drain");
  a_discard_on_entry: assert property ($rose(ABORT_DISCARD) |-> $rose(IN_DEBUG_HALT))
    else $error("discard rose without halt entry");
  a_discard_only_halt: assert property (ABORT_DISCARD |-> IN_DEBUG_HALT)
    else $error("discard set outside halt");
  a_run_abort_taken: assert property (ab && !ABORT_DISCARD && !ABORT_MASKED |=> ABORT_EXCEPTION)
    else $error("abort not taken");
  a_masked_abort_held: assert property (ab && !ABORT_DISCARD && ABORT_MASKED |=> ABORT_PENDING)
    else $error("masked abort lost");
  c_halt_abort: cover property (ab && ABORT_DISCARD);
  c_halt_entry: cover property ($rose(IN_DEBUG_HALT));
  c_masked_abort: cover property (ab && ABORT_MASKED && !ABORT_DISCARD);
endmodule : abort_discard_props
bind debug_async_abort_discard abort_discard_props chk (.*);

// >>> bench/debug_async_abort_discard_test.sv
// Self-checking bench for the abort discard block
`timescale 1ns/10ps
module debug_async_abort_discard_test;
  import abort_discard_pkg::*;
  logic CLOCK = 0, SRST = 1, HALT_REQUEST = 0, DEBUG_ACK = 0, STORE_ISSUE = 0, RESP_VALID = 0;
  logic RESP_NORMAL_MEM = 0, ABORT_MASKED = 0, leave = 0, err_seen;
  logic [1:0] RESP_CODE = 2'h0;
  logic RESTART_REQUEST, STICKY_CLEAR, IN_DEBUG_HALT, ABORT_DISCARD, ASYNC_ABORT_STICKY_FLAG, ABORT_PENDING;
  logic ABORT_EXCEPTION;
  int num_errors = 0, n_checks = 0;
  debug_async_abort_discard uut (.*);
  debugger_model dbg (.clk(CLOCK), .halted(IN_DEBUG_HALT), .sticky(ASYNC_ABORT_STICKY_FLAG), .leave(leave),
    .restart(RESTART_REQUEST), .clear(STICKY_CLEAR), .err_seen(err_seen));
  initial forever #2 CLOCK = ~CLOCK;
  task tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : tick
  task chk(input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task resp(input logic iss, input logic [1:0] c, input logic nm);
    STORE_ISSUE = iss;
    tick(1);
    STORE_ISSUE = 0;
    RESP_VALID = 1;
    RESP_CODE = c;
    RESP_NORMAL_MEM = nm;
    tick(1);
    RESP_VALID = 0;
  endtask : resp
  task wait_halt(input logic want);
    int i;
    for (i = 0; i < 40 && IN_DEBUG_HALT !== want; i++) tick(1);
    chk(want, IN_DEBUG_HALT);
    if (IN_DEBUG_HALT !== want) tally_and_finish();
  endtask : wait_halt
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task run_abort;
    DEBUG_ACK = 1;
    resp(1, 2'h2, 1);
    chk(1, ABORT_EXCEPTION);
    chk(0, ABORT_DISCARD);
    resp(1, 2'h2, 0);
    chk(0, ABORT_EXCEPTION);
    chk(0, ASYNC_ABORT_STICKY_FLAG);
    ABORT_MASKED = 1;
    resp(1, 2'h2, 1);
    chk(1, ABORT_PENDING);
    chk(0, ABORT_EXCEPTION);
    ABORT_MASKED = 0;
    tick(1);
    chk(1, ABORT_EXCEPTION);
    tick(2);
    chk(0, ABORT_PENDING);
    $display("run_abort done");
  endtask : run_abort
  task halt_cycle;
    STORE_ISSUE = 1;
    HALT_REQUEST = 1;
    tick(1);
    STORE_ISSUE = 0;
    HALT_REQUEST = 0;
    tick(8);
    chk(0, IN_DEBUG_HALT);
    resp(0, 2'h0, 1);
    wait_halt(1);
    chk(1, ABORT_DISCARD);
    resp(1, 2'h2, 1);
    chk(1, ASYNC_ABORT_STICKY_FLAG);
    chk(0, ABORT_EXCEPTION);
    // Non-blocking so the debugger model samples it one falling edge later, without a race
    leave <= 1'b1;
    wait_halt(0);
    leave <= 1'b0;
    chk(1, err_seen);
    chk(0, ASYNC_ABORT_STICKY_FLAG);
    chk(0, ABORT_DISCARD);
    $display("halt_cycle done");
  endtask : halt_cycle
  initial begin
    tick(12);
    SRST = 0;
    run_abort();
    halt_cycle();
    tally_and_finish();
  end
endmodule : debug_async_abort_discard_test

// >>> bench/debugger_model.sv
// Debugger that inspects the sticky abort flag before leaving halt
`timescale 1ns/10ps
module debugger_model (
  input wire logic clk,
  input wire logic halted,
  input wire logic sticky,
  input wire logic leave,
  output logic restart = 1'b0,
  output logic clear = 1'b0,
  output logic err_seen = 1'b0
);
  // A set flag on the way out counts as an error raised during debug
  always @(negedge clk) begin
    restart <= halted && leave && !restart;
    clear <= halted && leave && !restart && sticky;
    if (halted && leave && !restart) err_seen <= sticky;
  end
endmodule : debugger_model

// >>> include/abort_discard_pkg.sv
// Constants and types for the debug asynchronous abort discard block
package abort_discard_pkg;
  // Cycles of quiet on the write-response path before outstanding aborts count as recognized
  localparam int DRAIN_CYCLES = 4;
  localparam logic [2:0] DRAIN_RESET = 3'h0;
  localparam logic [1:0] BUS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RUN_STATE = 3'h1,
    DRAIN_STATE = 3'h2,
    HALT_STATE = 3'h4
  } debug_state_type;
endpackage : abort_discard_pkg

// >>> include/abort_event_if.sv
// Carrier between abort source detection and the discard controller
`timescale 1ns/10ps
interface abort_event_if;
  logic abort_seen;
  logic stores_pending;
  modport source (output abort_seen, output stores_pending);
  modport sink (input abort_seen, input stores_pending);
endinterface : abort_event_if

// >>> logic/abort_source.sv
// Turns store error responses into asynchronous abort events
`timescale 1ns/10ps
module abort_source
  import abort_discard_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic store_issue,
  input wire logic resp_valid,
  input wire logic [1:0] resp_code,
  input wire logic resp_normal_mem,
  abort_event_if.source events
);
  typedef struct packed {
    logic [3:0] outstanding;
  } src_state_type;

  src_state_type state;
  src_state_type next_state;

  always_comb begin
    next_state = state;
    if (srst) begin
      next_state.outstanding = 4'h0;
    end else if (store_issue && !resp_valid) begin
      next_state.outstanding = state.outstanding + 4'h1;
    end else if (!store_issue && resp_valid && state.outstanding != 4'h0) begin
      next_state.outstanding = state.outstanding - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  // Only buffered Normal-memory stores can fault after retirement
  assign events.abort_seen = resp_valid && resp_normal_mem && (resp_code == BUS_RESP_SLVERR);
  assign events.stores_pending = (state.outstanding != 4'h0) || store_issue;
endmodule : abort_source

// >>> logic/debug_async_abort_discard.sv
// Abort discard indicator and sticky abort flag around debug halt entry
// Behaviour
// - While discard is set, async aborts are dropped and only set the sticky flag.
// - Halt entry waits until every outstanding async abort is recognized.
// - Discard indicator is set immediately on entering debug halt.
// - Outside debug halt, recognized aborts are never discarded; exception taken normally.
// - Slave error on a store to Normal memory is an async abort.
`timescale 1ns/10ps
module debug_async_abort_discard
  import abort_discard_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic HALT_REQUEST,
  input wire logic RESTART_REQUEST,
  input wire logic DEBUG_ACK,
  input wire logic STORE_ISSUE,
  input wire logic RESP_VALID,
  input wire logic [1:0] RESP_CODE,
  input wire logic RESP_NORMAL_MEM,
  input wire logic ABORT_MASKED,
  input wire logic STICKY_CLEAR,
  output logic IN_DEBUG_HALT,
  output logic ABORT_DISCARD,
  output logic ASYNC_ABORT_STICKY_FLAG,
  output logic ABORT_PENDING,
  output logic ABORT_EXCEPTION
);
  typedef struct packed {
    debug_state_type mode;
    logic [2:0] drain;
    logic discard;
    logic sticky;
    logic pending;
    logic take;
  } ctl_state_type;

  ctl_state_type state;
  ctl_state_type next_state;
  abort_event_if events ();

  abort_source source_unit (
    .clock(CLOCK),
    .srst(SRST),
    .store_issue(STORE_ISSUE),
    .resp_valid(RESP_VALID),
    .resp_code(RESP_CODE),
    .resp_normal_mem(RESP_NORMAL_MEM),
    .events(events)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.take = 1'b0;
    case (state.mode)
      RUN_STATE: begin
        if (HALT_REQUEST) begin
          next_state.mode = DRAIN_STATE;
          next_state.drain = DRAIN_RESET;
        end
      end
      DRAIN_STATE: begin
        // Store responses may still be in flight; wait for a quiet stretch
        if (events.stores_pending || events.abort_seen) begin
          next_state.drain = DRAIN_RESET;
        end else if (state.drain == 3'(DRAIN_CYCLES - 1)) begin
          next_state.mode = HALT_STATE;
          next_state.discard = 1'b1;
        end else begin
          next_state.drain = state.drain + 3'h1;
        end
      end
      HALT_STATE: begin
        if (RESTART_REQUEST) begin
          next_state.mode = RUN_STATE;
          next_state.discard = 1'b0;
        end
      end
      default: begin
        next_state.mode = RUN_STATE;
        next_state.discard = 1'b0;
      end
    endcase

    // Abort handling uses the discard level of this cycle; debug ack plays no part
    if (events.abort_seen && state.discard) begin
      next_state.sticky = 1'b1;
    end else if (events.abort_seen || state.pending) begin
      if (ABORT_MASKED) begin
        next_state.pending = 1'b1;
      end else begin
        next_state.pending = 1'b0;
        next_state.take = 1'b1;
      end
    end
    // A new discarded abort wins over a clear in the same cycle
    if (STICKY_CLEAR && !(events.abort_seen && state.discard)) begin
      next_state.sticky = 1'b0;
    end

    if (SRST) begin
      next_state.mode = RUN_STATE;
      next_state.drain = DRAIN_RESET;
      next_state.discard = 1'b0;
      next_state.sticky = 1'b0;
      next_state.pending = 1'b0;
      next_state.take = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  assign IN_DEBUG_HALT = (state.mode == HALT_STATE);
  assign ABORT_DISCARD = state.discard;
  assign ASYNC_ABORT_STICKY_FLAG = state.sticky;
  assign ABORT_PENDING = state.pending;
  assign ABORT_EXCEPTION = state.take;

  // DEBUG_ACK is deliberately not used by the discard logic
  logic unused_ack;
  assign unused_ack = DEBUG_ACK;
endmodule : debug_async_abort_discard
